// file: rtl/dpm_map.svh
// address map, geometry and column layout constants of the dual-port memory
`ifndef DPM_MAP_SVH
`define DPM_MAP_SVH

// normal-word (32-bit) window of internal memory, block 1 and its aliases after block 0
`define DPM_NORMAL_BASE  20'h20000
`define DPM_NORMAL_LIMIT 20'h40000
// short-word (16-bit) view of the same storage
`define DPM_SHORT_BASE   20'h40000
`define DPM_SHORT_LIMIT  20'h80000
// size of one block in each addressing view
`define DPM_BLK_NORMAL   20'h04000
`define DPM_BLK_SHORT    20'h08000
// 48-bit words that fit in one block
`define DPM_W48_SPAN     20'h02000
// geometry of one block
`define DPM_COLS         8
`define DPM_DEPTH        4096
`define DPM_COL_BITS     16
// instruction cache entries
`define DPM_CACHE_LINES  32

`endif

// file: rtl/dpm_pkg.sv
// shared types of the dual-port on-chip memory
package dpm_pkg;

	typedef enum logic [1:0] {
		DPM_W16 = 2'h0,
		DPM_W32 = 2'h1,
		DPM_W48 = 2'h2
	} dpm_width_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		dpm_width_t  width;
		logic [19:0] addr;
		logic [47:0] wdata;
	} dpm_req_t;

	typedef struct packed {
		logic        valid;
		logic        retry;
		logic        error;
		logic [47:0] rdata;
	} dpm_resp_t;

	typedef struct packed {
		logic        hit;
		logic        blk;
		logic [11:0] row;
		logic [2:0]  col;
		logic [1:0]  ncol;
	} dpm_loc_t;

	typedef struct packed {
		logic        en;
		logic        we;
		logic [11:0] row;
		logic [2:0]  col;
		logic [1:0]  ncol;
		logic [47:0] wdata;
	} dpm_port_t;

	typedef struct packed {
		logic live;
		logic wr;
		logic retry;
		logic error;
		logic blk;
		logic cached;
		logic fill;
	} dpm_pipe_t;

endpackage

// file: rtl/dpm_block.sv
// one memory block: eight 16-bit columns, a core port and an i/o port
`timescale 1ns/10ps
`default_nettype none
`include "dpm_map.svh"

module dpm_block
	import dpm_pkg::*;
#(
	parameter int COLS  = `DPM_COLS,
	parameter int DEPTH = `DPM_DEPTH
) (
	input  wire logic      ref_clk,    // processor clock
	input  wire logic      reset_n,    // async reset, low active
	input  wire dpm_port_t core_port,  // core side access
	input  wire dpm_port_t io_port,    // i/o processor or dma access
	output logic [47:0]    core_rdata, // core read data, one cycle after access
	output logic [47:0]    io_rdata    // i/o read data, one cycle after access
);

	function automatic logic covers(int c, logic [2:0] col, logic [1:0] n);
		return (c >= int'(col)) && (c < int'(col) + int'(n));
	endfunction

	function automatic logic [15:0] lane(logic [47:0] d, int c, logic [2:0] col);
		logic [47:0] s;
		s = d >> (16 * (c - int'(col)));
		return s[15:0];
	endfunction

	function automatic logic [47:0] gather(logic [COLS*16-1:0] r, logic [2:0] col,
			logic [1:0] n);
		logic [47:0] g;
		g = '0;
		for (int k = 0; k < 3; k++) begin
			if (k < int'(n) && int'(col) + k < COLS) begin
				g[k*16 +: 16] = r[(int'(col) + k)*16 +: 16];
			end
		end
		return g;
	endfunction

	logic [COLS-1:0]    core_we;
	logic [COLS-1:0]    io_we;
	logic [15:0]        core_wd [COLS];
	logic [15:0]        io_wd [COLS];
	logic [COLS*16-1:0] core_row;
	logic [COLS*16-1:0] io_row;
	logic [2:0]         core_col;
	logic [2:0]         io_col;
	logic [1:0]         core_n;
	logic [1:0]         io_n;
	logic [2:0]         next_core_col;
	logic [2:0]         next_io_col;
	logic [1:0]         next_core_n;
	logic [1:0]         next_io_n;

	// column enables: a 16/32/48-bit word spans 1/2/3 columns of one row
	always_comb begin
		for (int c = 0; c < COLS; c++) begin
			core_we[c] = core_port.en & core_port.we & covers(c, core_port.col, core_port.ncol);
			io_we[c]   = io_port.en & io_port.we & covers(c, io_port.col, io_port.ncol);
			core_wd[c] = lane(core_port.wdata, c, core_port.col);
			io_wd[c]   = lane(io_port.wdata, c, io_port.col);
		end
		next_core_col = core_port.col;
		next_io_col   = io_port.col;
		next_core_n   = core_port.en ? core_port.ncol : 2'h0;
		next_io_n     = io_port.en ? io_port.ncol : 2'h0;
	end

	genvar gc;
	generate
		for (gc = 0; gc < COLS; gc++) begin : g_col
			logic [15:0] col_mem [DEPTH];

			// both ports act in the same cycle; core write lands last and wins
			always_ff @(posedge ref_clk) begin
				if (io_we[gc]) begin
					col_mem[io_port.row] <= io_wd[gc];
				end
				if (core_we[gc]) begin
					col_mem[core_port.row] <= core_wd[gc];
				end
				core_row[gc*16 +: 16] <= col_mem[core_port.row];
				io_row[gc*16 +: 16]   <= col_mem[io_port.row];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_col <= 3'h0;
			io_col   <= 3'h0;
			core_n   <= 2'h0;
			io_n     <= 2'h0;
		end else begin
			core_col <= next_core_col;
			io_col   <= next_io_col;
			core_n   <= next_core_n;
			io_n     <= next_io_n;
		end
	end

	assign core_rdata = gather(core_row, core_col, core_n);
	assign io_rdata   = gather(io_row, io_col, io_n);

endmodule

`default_nettype wire

// file: rtl/dpm_memory.sv
// dual-port on-chip memory: two blocks, core buses, i/o port, selective cache
`timescale 1ns/10ps
`default_nettype none
`include "dpm_map.svh"

module dpm_memory
	import dpm_pkg::*;
#(
	parameter int CACHE_LINES = `DPM_CACHE_LINES
) (
	input  wire logic     ref_clk,     // processor clock
	input  wire logic     reset_n,     // async reset, low active
	input  wire dpm_req_t dm_req,      // data_memory_bus access
	input  wire dpm_req_t pm_req,      // program_memory_bus data access
	input  wire logic     fetch_valid, // instruction fetch on program_memory_bus
	input  wire logic [19:0] fetch_addr, // instruction address, normal word
	input  wire dpm_req_t io_req,      // i/o processor or dma access
	output dpm_resp_t     dm_resp,     // data_memory_bus answer
	output dpm_resp_t     pm_resp,     // program_memory_bus data answer
	output dpm_resp_t     fetch_resp,  // instruction answer
	output dpm_resp_t     io_resp      // i/o answer
);

	localparam int IDXW = $clog2(CACHE_LINES);
	localparam int TAGW = 20 - IDXW;

	// map an address of the given width onto block, row and column group
	function automatic dpm_loc_t decode(dpm_req_t r);
		logic [19:0] off;
		dpm_loc_t    l;
		l = '0;
		if (r.width == DPM_W16) begin
			off    = r.addr - `DPM_SHORT_BASE;
			l.hit  = (r.addr >= `DPM_SHORT_BASE) && (r.addr < `DPM_SHORT_LIMIT);
			l.blk  = off >= `DPM_BLK_SHORT;
			l.row  = off[14:3];
			l.col  = off[2:0];
			l.ncol = 2'h1;
		end else begin
			off    = r.addr - `DPM_NORMAL_BASE;
			l.hit  = (r.addr >= `DPM_NORMAL_BASE) && (r.addr < `DPM_NORMAL_LIMIT);
			l.blk  = off >= `DPM_BLK_NORMAL;
			if (r.width == DPM_W48) begin
				l.hit  = l.hit && ({6'h00, off[13:0]} < `DPM_W48_SPAN);
				l.row  = off[12:1];
				l.col  = off[0] ? 3'h3 : 3'h0;
				l.ncol = 2'h3;
			end else begin
				l.row  = off[13:2];
				l.col  = {off[1:0], 1'b0};
				l.ncol = 2'h2;
			end
		end
		return l;
	endfunction

	function automatic dpm_port_t to_port(dpm_req_t r, dpm_loc_t l);
		dpm_port_t p;
		p.en    = 1'b1;
		p.we    = r.write;
		p.row   = l.row;
		p.col   = l.col;
		p.ncol  = l.ncol;
		p.wdata = r.wdata;
		return p;
	endfunction

	function automatic dpm_resp_t mk_resp(dpm_pipe_t p, logic [47:0] d);
		dpm_resp_t o;
		o.valid = p.live & ~p.retry;
		o.retry = p.retry;
		o.error = p.error;
		o.rdata = (p.live & ~p.retry & ~p.error & ~p.wr) ? d : 48'h0;
		return o;
	endfunction

	dpm_req_t   fetch_r;
	dpm_loc_t   ld;
	dpm_loc_t   lp;
	dpm_loc_t   lf;
	dpm_loc_t   li;
	logic       dm_go;
	logic       pm_go;
	logic       f_ok;
	logic       f_conf;
	logic       f_bus;
	logic       c_hit;
	logic       io_go;
	logic [IDXW-1:0] c_idx;
	logic [TAGW-1:0] c_tag;
	dpm_port_t  core_port [2];
	dpm_port_t  io_port [2];
	logic [47:0] core_rd [2];
	logic [47:0] io_rd [2];

	dpm_pipe_t  dm_p;
	dpm_pipe_t  pm_p;
	dpm_pipe_t  f_p;
	dpm_pipe_t  io_p;
	dpm_pipe_t  next_dm_p;
	dpm_pipe_t  next_pm_p;
	dpm_pipe_t  next_f_p;
	dpm_pipe_t  next_io_p;
	logic       fill_pend;
	logic       next_fill_pend;
	logic [19:0] fill_addr;
	logic [19:0] next_fill_addr;
	logic [19:0] faddr_q;
	logic [47:0] cdata_q;
	logic [47:0] next_cdata_q;

	logic [47:0]         cache_data [CACHE_LINES];
	logic [TAGW-1:0]     cache_tag [CACHE_LINES];
	logic [CACHE_LINES-1:0] cache_val;
	logic [CACHE_LINES-1:0] next_cache_val;
	logic                cache_we;
	logic [IDXW-1:0]     fill_idx;

	dpm_resp_t next_dm_resp;
	dpm_resp_t next_pm_resp;
	dpm_resp_t next_fetch_resp;
	dpm_resp_t next_io_resp;

	// arbitration of the core ports and the instruction cache
	always_comb begin
		fetch_r.valid = fetch_valid;
		fetch_r.write = 1'b0;
		fetch_r.width = DPM_W48;
		fetch_r.addr  = fetch_addr;
		fetch_r.wdata = 48'h0;
		ld = decode(dm_req);
		lp = decode(pm_req);
		lf = decode(fetch_r);
		li = decode(io_req);
		c_idx = fetch_addr[IDXW-1:0];
		c_tag = fetch_addr[19:IDXW];

		dm_go  = dm_req.valid & ld.hit;
		// two core transfers per cycle only when they sit in different blocks
		pm_go  = pm_req.valid & lp.hit & ~(dm_go & (ld.blk == lp.blk));
		f_ok   = fetch_valid & lf.hit;
		// program bus already carries data: fetch must come from the cache
		f_conf = f_ok & pm_req.valid;
		c_hit  = f_conf & cache_val[c_idx] & (cache_tag[c_idx] == c_tag);
		f_bus  = f_ok & ~pm_req.valid & ~(dm_go & (ld.blk == lf.blk));
		io_go  = io_req.valid & li.hit;

		for (int b = 0; b < 2; b++) begin
			core_port[b] = '0;
			io_port[b]   = '0;
			if (dm_go && ld.blk == 1'(b)) begin
				core_port[b] = to_port(dm_req, ld);
			end else if (pm_go && lp.blk == 1'(b)) begin
				core_port[b] = to_port(pm_req, lp);
			end else if (f_bus && lf.blk == 1'(b)) begin
				core_port[b] = to_port(fetch_r, lf);
			end
			if (io_go && li.blk == 1'(b)) begin
				io_port[b] = to_port(io_req, li);
			end
		end

		next_dm_p        = '0;
		next_dm_p.live   = dm_req.valid;
		next_dm_p.wr     = dm_req.write;
		next_dm_p.error  = dm_req.valid & ~ld.hit;
		next_dm_p.blk    = ld.blk;

		next_pm_p        = '0;
		next_pm_p.live   = pm_req.valid;
		next_pm_p.wr     = pm_req.write;
		next_pm_p.retry  = pm_req.valid & lp.hit & ~pm_go;
		next_pm_p.error  = pm_req.valid & ~lp.hit;
		next_pm_p.blk    = lp.blk;

		next_f_p         = '0;
		next_f_p.live    = fetch_valid;
		next_f_p.retry   = f_ok & ~f_bus & ~c_hit;
		next_f_p.error   = fetch_valid & ~lf.hit;
		next_f_p.blk     = lf.blk;
		next_f_p.cached  = c_hit;
		next_f_p.fill    = f_bus & fill_pend & (fetch_addr == fill_addr);

		next_io_p        = '0;
		next_io_p.live   = io_req.valid;
		next_io_p.wr     = io_req.write;
		next_io_p.error  = io_req.valid & ~li.hit;
		next_io_p.blk    = li.blk;

		// remember a colliding miss; a new collision wins over the fill clear
		next_fill_pend = fill_pend;
		next_fill_addr = fill_addr;
		if (next_f_p.fill) begin
			next_fill_pend = 1'b0;
		end
		if (f_conf && !c_hit) begin
			next_fill_pend = 1'b1;
			next_fill_addr = fetch_addr;
		end
		next_cdata_q = cache_data[c_idx];
	end

	genvar gb;
	generate
		for (gb = 0; gb < 2; gb++) begin : g_blk
			dpm_block #(
				.COLS  (`DPM_COLS),
				.DEPTH (`DPM_DEPTH)
			) u_block (
				.ref_clk    (ref_clk),
				.reset_n    (reset_n),
				.core_port  (core_port[gb]),
				.io_port    (io_port[gb]),
				.core_rdata (core_rd[gb]),
				.io_rdata   (io_rd[gb])
			);
		end
	endgenerate

	// answers and cache fill
	always_comb begin
		next_dm_resp    = mk_resp(dm_p, core_rd[dm_p.blk]);
		next_pm_resp    = mk_resp(pm_p, core_rd[pm_p.blk]);
		next_fetch_resp = mk_resp(f_p, f_p.cached ? cdata_q : core_rd[f_p.blk]);
		next_io_resp    = mk_resp(io_p, io_rd[io_p.blk]);
		fill_idx        = faddr_q[IDXW-1:0];
		cache_we        = f_p.live & f_p.fill;
		next_cache_val  = cache_val;
		if (cache_we) begin
			next_cache_val[fill_idx] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (cache_we) begin
			cache_data[fill_idx] <= core_rd[f_p.blk];
			cache_tag[fill_idx]  <= faddr_q[19:IDXW];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dm_p       <= '0;
			pm_p       <= '0;
			f_p        <= '0;
			io_p       <= '0;
			fill_pend  <= 1'b0;
			fill_addr  <= 20'h0;
			faddr_q    <= 20'h0;
			cdata_q    <= 48'h0;
			cache_val  <= '0;
			dm_resp    <= '0;
			pm_resp    <= '0;
			fetch_resp <= '0;
			io_resp    <= '0;
		end else begin
			dm_p       <= next_dm_p;
			pm_p       <= next_pm_p;
			f_p        <= next_f_p;
			io_p       <= next_io_p;
			fill_pend  <= next_fill_pend;
			fill_addr  <= next_fill_addr;
			faddr_q    <= fetch_addr;
			cdata_q    <= next_cdata_q;
			cache_val  <= next_cache_val;
			dm_resp    <= next_dm_resp;
			pm_resp    <= next_pm_resp;
			fetch_resp <= next_fetch_resp;
			io_resp    <= next_io_resp;
		end
	end

endmodule

`default_nettype wire

// file: verification/dpm_memory_monitor.sv
// port assertions of the dual-port memory
`timescale 1ns/10ps
`default_nettype none

module dpm_memory_monitor
	import dpm_pkg::*;
#(
	parameter int CACHE_LINES = 32
) (
	input wire logic        ref_clk,     // processor clock
	input wire logic        reset_n,     // async reset, low active
	input wire dpm_req_t    dm_req,      // data bus request
	input wire dpm_req_t    pm_req,      // program bus data request
	input wire logic        fetch_valid, // fetch request
	input wire logic [19:0] fetch_addr,  // fetch address
	input wire dpm_req_t    io_req,      // i/o request
	input wire dpm_resp_t   dm_resp,     // data bus answer
	input wire dpm_resp_t   pm_resp,     // program bus answer
	input wire dpm_resp_t   fetch_resp,  // fetch answer
	input wire dpm_resp_t   io_resp      // i/o answer
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// 32-bit normal-window requests, block 0 is 0x20000..0x23fff
	wire logic dm_n = dm_req.valid && dm_req.width == DPM_W32 && dm_req.addr[19:17] == 3'h1;
	wire logic pm_n = pm_req.valid && pm_req.width == DPM_W32 && pm_req.addr[19:17] == 3'h1;
	wire logic same = (dm_req.addr[19:14] == 6'h08) == (pm_req.addr[19:14] == 6'h08);
	// in-window fetch without program bus data, on the block that dm holds
	wire logic f_in = fetch_addr[19:17] == 3'h1 && fetch_addr[13:0] < 14'h2000;
	wire logic f_dm = fetch_valid && f_in && !pm_req.valid && dm_n &&
		((fetch_addr[19:14] == 6'h08) == (dm_req.addr[19:14] == 6'h08));

	a_dm_answer_two: assert property (dm_req.valid |-> ##2 dm_resp.valid && !dm_resp.retry)
		else $error("dm answer missing");
	a_dm_idle_quiet: assert property (!dm_req.valid |-> ##2 !dm_resp.valid)
		else $error("dm answer without request");
	a_io_write_done: assert property (io_req.valid && io_req.write |->
		##2 io_resp.valid && io_resp.rdata == 48'h0)
		else $error("io write answer wrong");
	a_split_blocks: assert property (dm_n && pm_n && !same |-> ##2 pm_resp.valid && !pm_resp.retry)
		else $error("pm refused on other block");
	a_same_block: assert property (dm_n && pm_n && same |-> ##2 pm_resp.retry && !pm_resp.valid)
		else $error("pm not retried on shared block");
	a_window_error: assert property (dm_req.valid && dm_req.width == DPM_W32 &&
		dm_req.addr[19:17] != 3'h1 |-> ##2 dm_resp.valid && dm_resp.error)
		else $error("out of window not flagged");
	a_fetch_alone: assert property (fetch_valid && !pm_req.valid && !dm_req.valid |->
		##2 fetch_resp.valid && !fetch_resp.retry)
		else $error("lone fetch not served");
	a_fetch_dm_clash: assert property (f_dm |-> ##2 fetch_resp.retry && !fetch_resp.valid)
		else $error("fetch not retried behind dm");
endmodule

bind dpm_memory dpm_memory_monitor #(.CACHE_LINES(CACHE_LINES)) u_dpm_memory_monitor (
	.ref_clk(ref_clk), .reset_n(reset_n), .dm_req(dm_req), .pm_req(pm_req),
	.fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .io_req(io_req),
	.dm_resp(dm_resp), .pm_resp(pm_resp), .fetch_resp(fetch_resp), .io_resp(io_resp));
`default_nettype wire

// file: verification/dpm_core_io_model.sv
// core and i/o requester model: one request set, answers taken two cycles on
`timescale 1ns/10ps
`default_nettype none

module dpm_core_io_model
	import dpm_pkg::*;
(
	input  wire logic      ref_clk,  // processor clock
	input  wire logic      reset_n,  // async reset, low active
	input  wire logic      go,       // launch one request set
	input  wire dpm_req_t  cmd [4],  // dm, pm, fetch, io requests
	output dpm_req_t       req [4],  // requests towards the memory
	input  wire dpm_resp_t resp [4], // answers from the memory
	output dpm_resp_t      got [4],  // captured answers
	output logic           done      // got is fresh
);
	logic [2:0] stage;

	// stage[0]: request on the buses, stage[1]: taken, stage[2]: answer stands
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= 3'h0;
			done <= 1'b0;
			req <= '{default: '0};
		end else begin
			stage <= {stage[1:0], go};
			done <= stage[2];
			// requests last one cycle, then the buses go idle
			foreach (req[k]) req[k] <= go ? cmd[k] : '0;
			if (stage[2]) got <= resp;
		end
	end
endmodule
`default_nettype wire

// file: verification/dpm_memory_bench.sv
// self-checking bench of the dual-port memory
`timescale 1ns/10ps
`default_nettype none

module dpm_memory_bench
	import dpm_pkg::*;
;
	localparam logic        rd  = 1'b0;
	localparam logic        wr  = 1'b1;
	localparam logic [47:0] nil = 48'h0;
	logic      ref_clk = 1'b0;
	logic      reset_n = 1'b0;
	logic      go = 1'b0;
	logic      done;
	dpm_req_t  cmd [4] = '{default: '0};
	dpm_req_t  req [4];
	dpm_resp_t resp [4];
	dpm_resp_t got [4];
	int        mismatches = 0;
	int        compares = 0;
	int        cycles = 0;

	always #2.5 ref_clk = ~ref_clk;

	dpm_core_io_model u_dpm_core_io_model (.ref_clk(ref_clk), .reset_n(reset_n), .go(go),
		.cmd(cmd), .req(req), .resp(resp), .got(got), .done(done));

	dpm_memory u_dpm_memory (.ref_clk(ref_clk), .reset_n(reset_n), .dm_req(req[0]),
		.pm_req(req[1]), .fetch_valid(req[2].valid), .fetch_addr(req[2].addr),
		.io_req(req[3]), .dm_resp(resp[0]), .pm_resp(resp[1]), .fetch_resp(resp[2]),
		.io_resp(resp[3]));

	function automatic dpm_req_t rq(logic w, dpm_width_t wd, logic [19:0] a, logic [47:0] d);
		rq = {1'b1, w, wd, a, d};
	endfunction

	task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// dm, pm, fetch, io launched together, answers land in got
	task automatic run(input dpm_req_t a, b, c, d);
		int n;
		n = 0;
		cmd = '{a, b, c, d};
		go = 1'b1;
		@(posedge ref_clk);
		#1 go = 1'b0;
		while (done !== 1'b1 && n < 16) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("answer", 48'h1, {47'h0, done});
	endtask

	task automatic t_widths;
		run(rq(wr, DPM_W48, 20'h20000, 48'h123456789abc), '0, '0, '0);
		run(rq(rd, DPM_W32, 20'h20000, nil), '0, '0, rq(rd, DPM_W16, 20'h40002, nil));
		chk("dm w32", 48'h56789abc, got[0].rdata);
		chk("io w16", 48'h1234, got[3].rdata);
		run('0, rq(rd, DPM_W48, 20'h20000, nil), '0, rq(rd, DPM_W16, 20'h40001, nil));
		chk("pm w48", 48'h123456789abc, got[1].rdata);
		chk("io w16 mid", 48'h5678, got[3].rdata);
	endtask

	task automatic t_map;
		run(rq(wr, DPM_W32, 20'h24010, 48'hcafe1234), '0, '0,
			rq(wr, DPM_W32, 20'h20010, 48'h0bad0f00));
		run(rq(rd, DPM_W32, 20'h3c010, nil), rq(rd, DPM_W32, 20'h20010, nil), '0,
			rq(rd, DPM_W16, 20'h48020, nil));
		chk("alias", 48'hcafe1234, got[0].rdata);
		chk("block0", 48'h0bad0f00, got[1].rdata);
		chk("pm retry", nil, {47'h0, got[1].retry});
		chk("block1 short", 48'h1234, got[3].rdata);
		run(rq(rd, DPM_W32, 20'h40000, nil), '0, '0, '0);
		chk("window error", 48'h1, {47'h0, got[0].error});
	endtask

	task automatic t_clash;
		run(rq(wr, DPM_W32, 20'h20020, 48'h11111111), '0, '0,
			rq(wr, DPM_W32, 20'h20020, 48'h22222222));
		chk("io write", 48'h1, {47'h0, got[3].valid});
		run(rq(rd, DPM_W32, 20'h20020, nil), rq(rd, DPM_W32, 20'h20021, nil), '0, '0);
		chk("core wins", 48'h11111111, got[0].rdata);
		chk("same block", 48'h1, {47'h0, got[1].retry});
	endtask

	task automatic t_cache;
		run('0, '0, '0, rq(wr, DPM_W48, 20'h24100, 48'hfeedface0001));
		run('0, rq(rd, DPM_W32, 20'h24200, nil), rq(rd, DPM_W48, 20'h24100, nil), '0);
		chk("miss retry", 48'h1, {47'h0, got[2].retry});
		run('0, '0, rq(rd, DPM_W48, 20'h24100, nil), '0);
		chk("refetch", 48'hfeedface0001, got[2].rdata);
		run(rq(rd, DPM_W32, 20'h20020, nil), rq(rd, DPM_W32, 20'h24200, nil),
			rq(rd, DPM_W48, 20'h24100, nil), rq(rd, DPM_W32, 20'h20010, nil));
		chk("cache hit", 48'hfeedface0001, got[2].rdata);
		chk("dm beside", 48'h11111111, got[0].rdata);
		chk("pm beside", nil, {47'h0, got[1].retry});
		chk("io beside", 48'h0bad0f00, got[3].rdata);
		run('0, '0, rq(rd, DPM_W48, 20'h24102, nil), '0);
		run('0, rq(rd, DPM_W32, 20'h24200, nil), rq(rd, DPM_W48, 20'h24102, nil), '0);
		chk("not cached", 48'h1, {47'h0, got[2].retry});
		run(rq(rd, DPM_W32, 20'h24200, nil), '0, rq(rd, DPM_W48, 20'h24100, nil), '0);
		chk("fetch vs dm", 48'h1, {47'h0, got[2].retry});
		chk("dm over fetch", 48'hface0001, got[0].rdata);
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		t_widths();
		t_map();
		t_clash();
		t_cache();
		print_verdict();
	end
endmodule
`default_nettype wire
